// ==== sls_pkg.sv ====
// Constants for the synthesizer serial write port and latch control.
// Assumes one system clock; the serial, strobe and chip enable pins are asynchronous to it.
package sls_pkg;

  localparam int WORD_W = 24;
  localparam int CUR_W = 3;
  localparam int SYNC_W = 4;

  // Latch select codes carried in the two low bits of every word.
  // They double as the register offsets of the four latches.
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;

  // Field positions inside the function and startup words.
  localparam int FN_CNT_RST_POS = 2;
  localparam int FN_PD_A_POS = 3;
  localparam int FN_PUMP_HIZ_POS = 4;
  localparam int FN_CUR1_LSB = 15;
  localparam int FN_CUR2_LSB = 18;
  localparam int FN_PD_B_POS = 21;
  localparam int FN_PRESC_LSB = 22;

  // Bit positions of the pin synchroniser vector.
  localparam int SY_SCLK = 0;
  localparam int SY_SDATA = 1;
  localparam int SY_STRB = 2;
  localparam int SY_CE = 3;

  // Values after reset.
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;

  typedef struct packed {
    logic [SYNC_W-1:0] sy1;
    logic [SYNC_W-1:0] sy2;
    logic sclk_prev;
    logic strb_prev;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] ref_l;
    logic [WORD_W-1:0] fb_l;
    logic [WORD_W-1:0] fn_l;
    logic [WORD_W-1:0] init_l;
    logic armed;
    logic pulse;
    logic sync_pd;
    logic pd;
    logic programmed;
  } sls_state_t;

endpackage : sls_pkg

// ==== sls_latch_load.sv ====
// Serial write port and latch control of a PLL frequency synthesizer.
// Assumes the serial pins, latch strobe and chip enable come from outside the
// clock domain; charge_pump_event comes from phase detector logic on clock.
//
// Notes on behaviour
// (R1) Data is shifted on each serial clock rise; strobe rise moves 24 bits to a latch.
// (R2) Host keeps the serial clock at or below 20 MHz.
// (R3) Host holds strobe low, sends three bytes, then raises strobe.
// (R4) Select code 00 loads the reference latch, 01 the feedback latch.
// (R5) Code 11 loads the startup latch; code 10 loads the function latch.
// (R6) A startup load copies the same word into the function latch.
// (R7) A startup load fires a reset pulse: counters to load state, pump three-stated.
// (R8) With chip enable high, select A high, select B low, the pulse powers down.
// (R9) The reset pulse leaves prescaler selection and input buffer untouched.
// (R10) Only the first feedback load after a startup load fires the pulse again.
// (R11) Startup method: startup, function, reference, feedback loads with counter reset 0.
// (R12) Chip enable low powers the device down immediately.
// (R13) Chip enable held low while programming; counting resumes aligned when raised.
// (R14) Latch contents survive chip enable power cycles.
// (R15) Counter reset method: function with reset 1, ref, feedback, function with 0.
// (R16) Counter reset bit holds counters and three-states pump, without power-down.
// (R17) Pump three-state bit 1 puts pump in high impedance, 0 enables it.
// (R18) Current setting one from low three bits, setting two from high three.
// (R19) Host picks prescaler so its output stays at or below 300 MHz.
// (R20) Host makes four writes after power-up before output is active.
// (R21) Function bit 2 is the counter reset bit; 1 holds counters.
// (R22) The input register keeps shifting and latching during any power-down.
// (R23) Words are sent most significant bit first; select bits arrive last.
module sls_latch_load
  import sls_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic chip_enable,
  input wire logic charge_pump_event,
  output logic [WORD_W-1:0] reference_divider_latch,
  output logic [WORD_W-1:0] feedback_divider_latch,
  output logic [WORD_W-1:0] function_settings_latch,
  output logic [WORD_W-1:0] startup_settings_latch,
  output logic counter_reset_pulse,
  output logic counters_hold,
  output logic charge_pump_hiz,
  output logic power_down,
  output logic [CUR_W-1:0] pump_current_1,
  output logic [CUR_W-1:0] pump_current_2,
  output logic [1:0] prescaler_sel,
  output logic programmed
);

  sls_state_t q;
  sls_state_t d;

  logic sclk_rise;
  logic strb_rise;
  logic ce_s;
  logic pd_a;
  logic pd_b;

  assign sclk_rise = q.sy2[SY_SCLK] & ~q.sclk_prev;
  assign strb_rise = q.sy2[SY_STRB] & ~q.strb_prev;
  assign ce_s = q.sy2[SY_CE];
  assign pd_a = q.fn_l[FN_PD_A_POS];
  assign pd_b = q.fn_l[FN_PD_B_POS];

  always_comb begin
    d = q;
    if (clk_en) begin
      d.pulse = 1'b0;
      d.sy1 = {chip_enable, latch_strobe, ser_data, ser_clk};
      d.sy2 = q.sy1;
      d.sclk_prev = q.sy2[SY_SCLK];
      d.strb_prev = q.sy2[SY_STRB];
      // Shifting ignores power-down so words can be loaded while disabled.
      if (sclk_rise) begin
        d.shift = {q.shift[WORD_W-2:0], q.sy2[SY_SDATA]}; // R1 R22 R23
      end
      if (strb_rise) begin
        d.programmed = 1'b1;
        unique case (q.shift[1:0])
          SEL_REF: begin
            d.ref_l = q.shift; // R4
          end
          SEL_FB: begin
            d.fb_l = q.shift; // R4
            if (q.armed) begin
              d.pulse = 1'b1; // R10
              d.armed = 1'b0; // R10
            end
          end
          SEL_FUNC: begin
            d.fn_l = q.shift; // R5
          end
          SEL_INIT: begin
            d.init_l = q.shift; // R5
            d.fn_l = q.shift; // R6
            d.pulse = 1'b1; // R7
            d.armed = 1'b1; // R10
          end
        endcase
      end
      // With select B set, synchronous power-down waits for a pump event so the loop sees no
      // frequency jump; clearing select A releases it.
      if (!pd_a) begin
        d.sync_pd = 1'b0;
      end else if (q.pulse && ce_s && !pd_b) begin
        d.sync_pd = 1'b1; // R8
      end else if (charge_pump_event && pd_b) begin
        d.sync_pd = 1'b1;
      end
      d.pd = ~ce_s | (pd_a & ~pd_b) | q.sync_pd; // R12 R13
    end
  end

  // Latches are cleared only by rst_n, never by chip enable.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q.sy1 <= SYNC_RST;
      q.sy2 <= SYNC_RST;
      q.sclk_prev <= 1'b0;
      q.strb_prev <= 1'b0;
      q.shift <= LATCH_RST;
      q.ref_l <= LATCH_RST;
      q.fb_l <= LATCH_RST;
      q.fn_l <= LATCH_RST;
      q.init_l <= LATCH_RST;
      q.armed <= 1'b0;
      q.pulse <= 1'b0;
      q.sync_pd <= 1'b0;
      q.pd <= 1'b1;
      q.programmed <= 1'b0;
    end else begin
      q <= d; // R14
    end
  end

  assign reference_divider_latch = q.ref_l;
  assign feedback_divider_latch = q.fb_l;
  assign function_settings_latch = q.fn_l;
  assign startup_settings_latch = q.init_l;
  assign counter_reset_pulse = q.pulse;
  assign power_down = q.pd;
  assign programmed = q.programmed;
  assign counters_hold = q.pulse | q.fn_l[FN_CNT_RST_POS] | q.pd; // R7 R16 R21
  // The pump stays quiet until the first word has been taken.
  assign charge_pump_hiz = counters_hold | q.fn_l[FN_PUMP_HIZ_POS] | ~q.programmed; // R17
  assign pump_current_1 = q.fn_l[FN_CUR1_LSB +: CUR_W]; // R18
  assign pump_current_2 = q.fn_l[FN_CUR2_LSB +: CUR_W]; // R18
  // Prescaler selection bypasses the reset pulse to keep phase alignment.
  assign prescaler_sel = q.fn_l[FN_PRESC_LSB +: 2]; // R9

  sequence s_load(logic [1:0] code);
    clk_en && strb_rise && !sclk_rise && q.shift[1:0] == code;
  endsequence

  property p_shift;
    @(posedge clock) disable iff (!rst_n)
      clk_en && sclk_rise |=> q.shift == {$past(q.shift[WORD_W-2:0]), $past(q.sy2[SY_SDATA])};
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted in"); // R1

  property p_ref_load;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_REF) |=> reference_divider_latch == $past(q.shift);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference latch not loaded"); // R4

  property p_fb_load;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FB) |=> feedback_divider_latch == $past(q.shift);
  endproperty
  a_fb_load: assert property (p_fb_load) else $error("feedback latch not loaded"); // R4

  property p_init_load;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_INIT) |=> startup_settings_latch == $past(q.shift)
        && function_settings_latch == $past(q.shift);
  endproperty
  a_init_load: assert property (p_init_load) else $error("startup load wrong"); // R5 R6

  property p_init_pulse;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_INIT) |=> counter_reset_pulse && counters_hold && charge_pump_hiz;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("no reset pulse on startup"); // R7

  property p_second_fb;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FB) && !q.armed |=> !counter_reset_pulse;
  endproperty
  a_second_fb: assert property (p_second_fb) else $error("pulse on later feedback load"); // R10

  property p_first_fb;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FB) && q.armed |=> counter_reset_pulse ##1 !q.armed;
  endproperty
  a_first_fb: assert property (p_first_fb) else $error("no pulse on first feedback"); // R10

  property p_ce_low;
    @(posedge clock) disable iff (!rst_n)
      clk_en && !ce_s |=> power_down;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("chip enable low not powered down"); // R12

  property p_cnt_rst;
    @(posedge clock) disable iff (!rst_n)
      function_settings_latch[FN_CNT_RST_POS] |-> counters_hold && charge_pump_hiz;
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset not holding"); // R16 R21

  property p_cp_hiz;
    @(posedge clock) disable iff (!rst_n)
      function_settings_latch[FN_PUMP_HIZ_POS] |-> charge_pump_hiz;
  endproperty
  a_cp_hiz: assert property (p_cp_hiz) else $error("pump not three-stated"); // R17

  property p_sync_pd;
    @(posedge clock) disable iff (!rst_n)
      clk_en && q.pulse && ce_s && pd_a && !pd_b ##1 clk_en |=> power_down;
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("pulse did not power down"); // R8

  property p_currents;
    @(posedge clock) disable iff (!rst_n)
      pump_current_1 == function_settings_latch[FN_CUR1_LSB +: CUR_W]
        && pump_current_2 == function_settings_latch[FN_CUR2_LSB +: CUR_W];
  endproperty
  a_currents: assert property (p_currents) else $error("pump currents mismatch"); // R18

  property p_pd_shift;
    @(posedge clock) disable iff (!rst_n)
      clk_en && power_down && sclk_rise |=> q.shift[0] == $past(q.sy2[SY_SDATA])
        && q.shift[WORD_W-1:1] == $past(q.shift[WORD_W-2:0]);
  endproperty
  a_pd_shift: assert property (p_pd_shift) else $error("shifting stopped in power-down"); // R22

  // The checks below cover freezing, pulse shape and latch retention.
  // A cycle without a strobe rise must leave every latch and the prescaler alone.
  sequence s_no_load;
    clk_en && !strb_rise;
  endsequence

  sequence s_pulse_out;
    counter_reset_pulse && counters_hold && charge_pump_hiz;
  endsequence

  property p_freeze;
    @(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_func_load;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FUNC) |=> function_settings_latch == $past(q.shift);
  endproperty
  a_func_load: assert property (p_func_load) else $error("function latch not loaded"); // R5

  property p_func_keep_init;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FUNC) |=> $stable(startup_settings_latch);
  endproperty
  a_func_keep_init: assert property (p_func_keep_init) else $error("startup latch hit"); // R5

  property p_pulse_one;
    @(posedge clock) disable iff (!rst_n)
      clk_en && counter_reset_pulse |=> !counter_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long"); // R7

  // Codes 01 and 11 are the only ones with bit 0 set, so they alone may pulse.
  property p_pulse_cause;
    @(posedge clock) disable iff (!rst_n)
      clk_en && !(strb_rise && q.shift[0]) |=> !counter_reset_pulse;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without cause"); // R7 R10

  property p_fb_pulse_shape;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_FB) && q.armed |=> s_pulse_out;
  endproperty
  a_fb_pulse_shape: assert property (p_fb_pulse_shape) else $error("feedback pulse shape"); // R10

  property p_armed_set;
    @(posedge clock) disable iff (!rst_n)
      s_load(SEL_INIT) |=> q.armed;
  endproperty
  a_armed_set: assert property (p_armed_set) else $error("startup load did not arm"); // R10

  property p_presc_stable;
    @(posedge clock) disable iff (!rst_n)
      s_no_load |=> $stable(prescaler_sel);
  endproperty
  a_presc_stable: assert property (p_presc_stable) else $error("prescaler moved"); // R9

  property p_latch_keep;
    @(posedge clock) disable iff (!rst_n)
      s_no_load |=> $stable(reference_divider_latch) && $stable(feedback_divider_latch)
        && $stable(function_settings_latch) && $stable(startup_settings_latch);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch lost its contents"); // R14

  property p_ce_high;
    @(posedge clock) disable iff (!rst_n)
      clk_en && ce_s && !pd_a && !q.sync_pd |=> !power_down;
  endproperty
  a_ce_high: assert property (p_ce_high) else $error("chip enable high still down"); // R13

  property p_pd_latch;
    @(posedge clock) disable iff (!rst_n)
      power_down ##0 s_load(SEL_FUNC) |=> function_settings_latch == $past(q.shift);
  endproperty
  a_pd_latch: assert property (p_pd_latch) else $error("no load in power-down"); // R22

  // Synchronous power-down has only two causes; the counter reset bit is not one.
  property p_no_sync_pd;
    @(posedge clock) disable iff (!rst_n)
      clk_en && !q.pulse && !(charge_pump_event && pd_b) && !q.sync_pd |=> !q.sync_pd;
  endproperty
  a_no_sync_pd: assert property (p_no_sync_pd) else $error("unexpected timed power-down"); // R16

  property p_pd_hold;
    @(posedge clock) disable iff (!rst_n)
      power_down |-> counters_hold && charge_pump_hiz;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down left pump active"); // R12

  property p_pump_on;
    @(posedge clock) disable iff (!rst_n)
      programmed && !counters_hold && !function_settings_latch[FN_PUMP_HIZ_POS]
        |-> !charge_pump_hiz;
  endproperty
  a_pump_on: assert property (p_pump_on) else $error("pump not enabled"); // R17

  property p_prog_set;
    @(posedge clock) disable iff (!rst_n)
      clk_en && strb_rise |=> programmed;
  endproperty
  a_prog_set: assert property (p_prog_set) else $error("load not marked as programmed"); // R1

endmodule : sls_latch_load

// ==== sls_host_model.sv ====
// Serial master model that writes 24-bit words into the latch port.
// Assumes a 50 ns bench clock; the serial clock is built from it.
module sls_host_model (
  input wire logic clock,
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // The serial clock rests low between frames, as a real master leaves it.
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (4) @(posedge clock);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clock);
      ser_clk <= 1'b0;
    end
    // Data is not held after the last bit, so the line shows its inverse.
    ser_data <= ~w[0];
    repeat (4) @(posedge clock);
    latch_strobe <= 1'b1;
    repeat (8) @(posedge clock);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : send
endmodule : sls_host_model

// ==== test_synth_latch_load_and_init.sv ====
// Self-checking bench for the serial latch port, driven by the host model.
// Assumes the charge pump event input stays idle, so a timed power-down only follows a reset pulse.
module test_synth_latch_load_and_init;
  import sls_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, ce, ser_clk, ser_data, strobe;
  logic [WORD_W-1:0] got [4];
  logic [WORD_W-1:0] exp_l [4];
  logic [WORD_W-1:0] ref_q, fb_q, fn_q, init_q;
  logic pulse, hold, hiz, pd, prog, armed;
  logic [CUR_W-1:0] cur1, cur2;
  logic [1:0] presc;
  int fails, num_checks, pulses, cyc;
  assign got = '{ref_q, fb_q, fn_q, init_q};
  sls_host_model sls_host_model_i (.clock(clock), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(strobe));
  sls_latch_load sls_latch_load_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(strobe), .chip_enable(ce),
    .charge_pump_event(1'b0), .reference_divider_latch(ref_q), .feedback_divider_latch(fb_q),
    .function_settings_latch(fn_q), .startup_settings_latch(init_q),
    .counter_reset_pulse(pulse), .counters_hold(hold), .charge_pump_hiz(hiz),
    .power_down(pd), .pump_current_1(cur1), .pump_current_2(cur2), .prescaler_sel(presc),
    .programmed(prog));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // A pulse only counts when it also holds the counters and floats the pump.
  always @(posedge clock) begin
    cyc++;
    if (pulse === 1'b1 && hold === 1'b1 && hiz === 1'b1) pulses++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [23:0] rw(input logic [1:0] c, input logic cr);
    rw = 24'($urandom);
    rw[FN_PD_B_POS] = 1'b0;
    rw[FN_CNT_RST_POS] = cr;
    rw[1:0] = c;
  endfunction : rw
  task automatic load(input logic [23:0] w);
    int p0;
    logic [23:0] f;
    logic ep, epd;
    p0 = pulses;
    ep = (w[1:0] == SEL_INIT) || (w[1:0] == SEL_FB && armed);
    sls_host_model_i.send(w);
    exp_l[w[1:0]] = w;
    if (w[1:0] == SEL_INIT) exp_l[SEL_FUNC] = w;
    armed = (w[1:0] == SEL_INIT) || (armed && w[1:0] != SEL_FB);
    f = exp_l[SEL_FUNC];
    epd = !ce || (f[FN_PD_A_POS] && !f[FN_PD_B_POS]);
    chk(24'(pulses - p0), {23'h0, ep});
    for (int k = 0; k < 4; k++) chk(got[k], exp_l[k]);
    chk({16'h0, presc, cur2, cur1}, {16'h0, f[23:22], f[20:15]});
    chk({20'h0, hold, hiz, pd, prog}, {20'h0, f[2] | epd, f[2] | epd | f[4], epd, 1'b1});
  endtask : load
  task automatic test_done();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    armed = 1'b0;
    exp_l = '{default: 24'h000000};
    void'($urandom(99711));
    repeat (8) @(posedge clock);
    chk({20'h0, hold, hiz, pd, prog}, 24'h00000e);
    rst_n <= 1'b1;
    load(rw(SEL_INIT, 1'b0));
    load(rw(SEL_FUNC, 1'b0));
    load(rw(SEL_REF, 1'b0));
    load(rw(SEL_FB, 1'b0));
    load(rw(SEL_FB, 1'b0));
    ce <= 1'b0;
    load(rw(SEL_FUNC, 1'b0));
    load(rw(SEL_REF, 1'b0));
    load(rw(SEL_FB, 1'b0));
    ce <= 1'b1;
    load(rw(SEL_REF, 1'b0));
    load(rw(SEL_FUNC, 1'b1));
    load(rw(SEL_REF, 1'b0));
    load(rw(SEL_FB, 1'b0));
    load(rw(SEL_FUNC, 1'b0));
    repeat (14) begin
      ce <= ($urandom % 4) != 0;
      load(rw(2'($urandom), 1'($urandom)));
    end
    test_done();
  end
endmodule : test_synth_latch_load_and_init
